// ===== dsmcr_pkg.sv
// Purpose: shared constants and types of the dual slot card mux control block
// Assumes: 8-bit registers addressed by a command byte over a two-wire serial slave
// Notes: slave addresses are the 7-bit forms of the 8-bit bus addresses
package dsmcr_pkg;
  // command byte offsets
  localparam logic [7:0] OFF_HW_ID = 8'h00;
  localparam logic [7:0] OFF_SW_VER = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  // values after reset
  localparam logic [7:0] RST_SW_VER = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // slave address chosen by the strap level (8-bit 78h/79h and 7ah/7bh)
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h3c;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h3d;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // cycles the data relay waits after releasing a line before it may drive again
  localparam logic [1:0] RELAY_GUARD = 2'h3;
  // slot interface states, also the status codes
  localparam logic [1:0] ST_OFF = 2'h0;
  localparam logic [1:0] ST_ISOLATED = 2'h1;
  localparam logic [1:0] ST_POWERED = 2'h2;
  localparam logic [1:0] ST_ACTIVE = 2'h3;

  // one nibble of the control register, slot a in the low nibble
  typedef struct packed {
    logic [1:0] state;
    logic vsel;
    logic reg_en;
  } dsmcr_slot_ctrl_type;

  // every input that arrives from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic irq;
    logic rst_n;
    logic card_rst;
    logic card_clk;
    logic host_data;
    logic a_data;
    logic b_data;
  } dsmcr_pins_type;

  localparam dsmcr_pins_type PINS_IDLE = dsmcr_pins_type'(9'h1ff);

  typedef enum logic [3:0] {
    SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_CMD, SER_CMD_ACK,
    SER_WDATA, SER_WDATA_ACK, SER_RDATA, SER_RDATA_ACK
  } dsmcr_ser_state_type;
endpackage

// ===== dsmcr_top.sv
// Purpose: register bank, serial slave, strap, interrupt and card mux of the dual slot block
// Assumes: pins and link clock are asynchronous to sys_clk and pass two flip-flops
// Notes: open-drain pins drive low only, the enable is high while driving
// Notes on behaviour
// - read-only id byte at command 00h, maker and device id combined
// - maker id in the upper nibble, fixed whatever the hardware revision
// - read-only driver version byte at command 01h, zero in first silicon
// - driver version only changes when a revision needs host driver changes
// - interrupt pin pulled low toward the host while an event is pending
// - interrupt pin level caught after reset selects the slave address
// - low reset input holds the whole block in reset except the pin synchronisers
// - host card reset and clock forwarded to the selected slot only
// - strap low answers 78h/79h, strap high answers 7ah/7bh
// - status per slot: 00 off, 01 isolated, 10 powered, 11 active
// - control holds per slot enable, voltage, state; state 10 not blocked
// - reset clears pending event, defaults registers, regulators off, slots low
`timescale 1ns/100ps
module dsmcr_top #(
  parameter logic [3:0] MAKER_ID = 4'h5, // arbitrary value
  parameter logic [3:0] DEVICE_ID = 4'h2, // arbitrary value
  parameter logic [7:0] DRIVER_VERSION = dsmcr_pkg::RST_SW_VER
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic irq_in,
  output logic irq_out,
  output logic irq_oe,
  input wire logic host_card_reset,
  input wire logic host_card_clock,
  input wire logic host_card_data_in,
  output logic host_card_data_out,
  output logic host_card_data_oe,
  output logic slot_a_card_reset,
  output logic slot_a_card_clock,
  input wire logic slot_a_card_data_in,
  output logic slot_a_card_data_out,
  output logic slot_a_card_data_oe,
  output logic slot_a_supply_en,
  output logic slot_a_supply_sel,
  output logic slot_a_pulldown,
  output logic slot_b_card_reset,
  output logic slot_b_card_clock,
  input wire logic slot_b_card_data_in,
  output logic slot_b_card_data_out,
  output logic slot_b_card_data_oe,
  output logic slot_b_supply_en,
  output logic slot_b_supply_sel,
  output logic slot_b_pulldown
);
  import dsmcr_pkg::*;

  dsmcr_pins_type pin_meta, pin, pin_prev;
  logic ires, scl_rise, scl_fall, start_seen, stop_seen;
  logic strap_done, addr_high, irq_pend;
  dsmcr_ser_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx, ptr, rdata, status;
  logic rw, nack, sda_drv, byte_done, tx_load, wr_ctrl, rd_status;
  logic [6:0] my_addr;
  dsmcr_slot_ctrl_type [1:0] ctrl;
  logic sel_a, sel_b, sel_a_q, sel_b_q, card_low;
  logic host_drv, card_drv, next_card_drv;
  logic [1:0] guard;

  // two-stage synchronisers, third stage only feeds edge detection; they run
  // through reset so the strap sample at release sees the real pin level
  always_ff @(posedge sys_clk) begin
    pin_meta <= {scl_in, sda_in, irq_in, host_reset_n_in, host_card_reset,
                 host_card_clock, host_card_data_in, slot_a_card_data_in,
                 slot_b_card_data_in};
    pin <= pin_meta;
    pin_prev <= pin;
  end

  assign ires = rst | ~pin.rst_n;
  assign scl_rise = pin.scl & ~pin_prev.scl;
  assign scl_fall = ~pin.scl & pin_prev.scl;
  assign start_seen = pin.scl & pin_prev.scl & ~pin.sda & pin_prev.sda;
  assign stop_seen = pin.scl & pin_prev.scl & pin.sda & ~pin_prev.sda;

  // strap caught once after release; pin is not driven until then
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      strap_done <= 1'b0;
      addr_high <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      addr_high <= pin.irq;
    end
  end

  assign my_addr = addr_high ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
  assign byte_done = scl_fall && (bit_cnt == BYTE_BITS);
  assign tx_load = scl_fall && ((state == SER_ADDR_ACK && rw) ||
                                (state == SER_RDATA_ACK && !nack));
  assign wr_ctrl = byte_done && state == SER_WDATA && ptr == OFF_CTRL;
  assign rd_status = tx_load && ptr == OFF_STATUS;

  // read mux; unmapped commands read as zero
  always_comb begin
    if (ptr == OFF_HW_ID) begin
      rdata = {MAKER_ID, DEVICE_ID};
    end else if (ptr == OFF_SW_VER) begin
      rdata = DRIVER_VERSION;
    end else if (ptr == OFF_STATUS) begin
      rdata = status;
    end else if (ptr == OFF_CTRL) begin
      rdata = ctrl;
    end else begin
      rdata = 8'h00;
    end
  end

  // serial slave: sample on scl rise, change sda on scl fall
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      state <= SER_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= OFF_HW_ID;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_drv <= 1'b0;
    end else if (start_seen) begin
      state <= SER_ADDR; // repeated start keeps the pointer
      bit_cnt <= 4'h0;
      sda_drv <= 1'b0;
    end else if (stop_seen) begin
      state <= SER_IDLE;
      sda_drv <= 1'b0;
    end else if (scl_rise) begin
      if (state == SER_RDATA_ACK) begin
        nack <= pin.sda;
      end else if (state == SER_ADDR || state == SER_CMD || state == SER_WDATA ||
                   state == SER_RDATA) begin
        shreg <= {shreg[6:0], pin.sda};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (scl_fall) begin
      case (state)
        SER_ADDR: begin
          if (byte_done) begin
            if (shreg[7:1] == my_addr) begin
              state <= SER_ADDR_ACK;
              rw <= shreg[0];
              sda_drv <= 1'b1;
            end else begin
              state <= SER_IDLE;
            end
          end
        end
        SER_ADDR_ACK, SER_RDATA_ACK: begin
          bit_cnt <= 4'h0;
          if (tx_load) begin
            state <= SER_RDATA;
            tx <= rdata;
            sda_drv <= ~rdata[7];
          end else if (state == SER_ADDR_ACK) begin
            state <= SER_CMD; // command byte comes first on a write
            sda_drv <= 1'b0;
          end else begin
            state <= SER_IDLE; // host refused the byte
            sda_drv <= 1'b0;
          end
        end
        SER_CMD: begin
          if (byte_done) begin
            ptr <= shreg;
            state <= SER_CMD_ACK;
            sda_drv <= 1'b1;
          end
        end
        SER_WDATA: begin
          if (byte_done) begin
            state <= SER_WDATA_ACK;
            sda_drv <= 1'b1;
          end
        end
        SER_CMD_ACK, SER_WDATA_ACK: begin
          state <= SER_WDATA; // pointer does not advance
          bit_cnt <= 4'h0;
          sda_drv <= 1'b0;
        end
        SER_RDATA: begin
          if (byte_done) begin
            state <= SER_RDATA_ACK;
            sda_drv <= 1'b0;
          end else begin
            tx <= {tx[6:0], 1'b0};
            sda_drv <= ~tx[6];
          end
        end
        default: begin
          state <= SER_IDLE;
        end
      endcase
    end
  end

  // control register; read-only registers ignore writes
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= shreg; // state 10 stored as written
    end
  end

  // status code per slot from state and regulator bits
  for (genvar s = 0; s < 2; s++) begin : g_status
    always_ff @(posedge sys_clk) begin
      if (ires) begin
        status[4+2*s +: 2] <= RST_STATUS[4+2*s +: 2];
      end else if (ctrl[s].state == ST_OFF && ctrl[s].reg_en) begin
        status[4+2*s +: 2] <= ST_POWERED;
      end else begin
        status[4+2*s +: 2] <= ctrl[s].state;
      end
    end
  end
  assign status[3:0] = 4'h0;

  // slot a wins if software makes both active
  assign sel_a = status[5:4] == ST_ACTIVE;
  assign sel_b = status[7:6] == ST_ACTIVE && !sel_a;
  assign card_low = (sel_a && !pin.a_data) || (sel_b && !pin.b_data);

  // pending event on every change of the selected slot; a status read clears
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      sel_a_q <= 1'b0;
      sel_b_q <= 1'b0;
      irq_pend <= 1'b0;
    end else begin
      sel_a_q <= sel_a;
      sel_b_q <= sel_b;
      if (sel_a != sel_a_q || sel_b != sel_b_q) begin
        irq_pend <= 1'b1; // set wins over the clearing read
      end else if (rd_status) begin
        irq_pend <= 1'b0;
      end
    end
  end

  // interrupt pin held off until the strap has been taken
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= irq_pend && strap_done;
    end
  end

  // regulator and pull-down pins follow control and status
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      slot_a_supply_en <= 1'b0;
      slot_a_supply_sel <= 1'b0;
      slot_a_pulldown <= 1'b1;
      slot_b_supply_en <= 1'b0;
      slot_b_supply_sel <= 1'b0;
      slot_b_pulldown <= 1'b1;
    end else begin
      slot_a_supply_en <= ctrl[0].reg_en;
      slot_a_supply_sel <= ctrl[0].vsel;
      slot_a_pulldown <= !status[4];
      slot_b_supply_en <= ctrl[1].reg_en;
      slot_b_supply_sel <= ctrl[1].vsel;
      slot_b_pulldown <= !status[6];
    end
  end

  // reset and clock forwarding; link clock is resampled, so jitter is one cycle
  always_ff @(posedge sys_clk) begin
    if (ires) begin
      slot_a_card_reset <= 1'b0;
      slot_a_card_clock <= 1'b0;
      slot_b_card_reset <= 1'b0;
      slot_b_card_clock <= 1'b0;
    end else begin
      slot_a_card_reset <= sel_a && pin.card_rst;
      slot_a_card_clock <= sel_a && pin.card_clk;
      slot_b_card_reset <= sel_b && pin.card_rst;
      slot_b_card_clock <= sel_b && pin.card_clk;
    end
  end

  // data relay: whichever side pulls low first owns the line; the guard
  // masks our own released low still in the synchroniser, avoiding latch-up
  assign next_card_drv = (sel_a || sel_b) && !pin.host_data && !host_drv &&
                         (card_drv || guard == 2'h0);

  always_ff @(posedge sys_clk) begin
    if (ires) begin
      host_drv <= 1'b0;
      card_drv <= 1'b0;
      slot_a_card_data_oe <= 1'b0;
      slot_b_card_data_oe <= 1'b0;
      guard <= 2'h0;
    end else begin
      card_drv <= next_card_drv;
      slot_a_card_data_oe <= next_card_drv && sel_a;
      slot_b_card_data_oe <= next_card_drv && sel_b;
      host_drv <= card_low && !card_drv && (host_drv || guard == 2'h0);
      if ((card_drv && pin.host_data) || (host_drv && !card_low)) begin
        guard <= RELAY_GUARD;
      end else if (guard != 2'h0) begin
        guard <= guard - 2'h1;
      end
    end
  end

  assign host_card_data_oe = host_drv;
  assign sda_oe = sda_drv;
  assign sda_out = 1'b0;
  assign irq_out = 1'b0;
  assign host_card_data_out = 1'b0;
  assign slot_a_card_data_out = 1'b0;
  assign slot_b_card_data_out = 1'b0;

  property p_hw_id;
    @(posedge sys_clk) disable iff (ires)
      tx_load && ptr == OFF_HW_ID |=> tx[7:4] == MAKER_ID && tx[3:0] == DEVICE_ID;
  endproperty
  a_hw_id: assert property (p_hw_id) else $error("id byte wrong");

  property p_sw_ver;
    @(posedge sys_clk) disable iff (ires)
      tx_load && ptr == OFF_SW_VER |=> tx == DRIVER_VERSION;
  endproperty
  a_sw_ver: assert property (p_sw_ver) else $error("version byte wrong");

  property p_irq;
    @(posedge sys_clk) disable iff (ires)
      $rose(irq_pend) && strap_done |=> irq_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not driven");

  property p_strap;
    @(posedge sys_clk) disable iff (ires)
      strap_done |=> $stable(addr_high) && strap_done;
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed");

  property p_addr;
    @(posedge sys_clk) disable iff (ires)
      state == SER_ADDR && byte_done && !start_seen && !stop_seen &&
      shreg[7:1] == (addr_high ? 7'h3d : 7'h3c) |=> state == SER_ADDR_ACK && sda_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("own address not acked");

  property p_reset;
    @(posedge sys_clk) !pin.rst_n |=> ctrl == 8'h00 && state == SER_IDLE && !irq_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("reset input ignored");

  property p_forward;
    @(posedge sys_clk) disable iff (ires)
      !sel_a |=> !slot_a_card_clock && !slot_a_card_reset;
  endproperty
  a_forward: assert property (p_forward) else $error("unselected slot driven");

  property p_status;
    @(posedge sys_clk) disable iff (ires)
      ctrl[0].state == 2'h0 && ctrl[0].reg_en ##1 ctrl[0].state == 2'h0 |->
      status[5:4] == 2'h2;
  endproperty
  a_status: assert property (p_status) else $error("status code wrong");

  property p_ctrl_wr;
    @(posedge sys_clk) disable iff (ires)
      wr_ctrl && !start_seen && !stop_seen |=> ctrl == $past(shreg);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_defaults;
    @(posedge sys_clk) ires |=> !slot_a_supply_en && !slot_b_supply_en &&
      slot_a_pulldown && slot_b_pulldown && !slot_a_card_clock && !irq_pend;
  endproperty
  a_defaults: assert property (p_defaults) else $error("reset defaults wrong");

  c_ctrl_wr: cover property (@(posedge sys_clk) disable iff (ires) wr_ctrl);
  c_status_rd: cover property (@(posedge sys_clk) disable iff (ires) rd_status);
  c_slot_a: cover property (@(posedge sys_clk) disable iff (ires) sel_a ##1 sel_b);
  c_high_addr: cover property (@(posedge sys_clk) disable iff (ires)
    addr_high && state == SER_ADDR_ACK);
endmodule

// ===== dsmcr_host_model.sv
// Purpose: baseband model, two-wire master with register access tasks
// Assumes: pull-up on the data line, the clock line driven only here
// Notes: every change lands on a falling sys_clk edge, phases of HALF cycles
`timescale 1ns/100ps
module dsmcr_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // ten cycles a phase, well above the sampling minimum of four
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(negedge sys_clk);
  endtask
  // data moves only while the clock line is low
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    tick();
    scl = 1'b1;
    tick();
    s = sda_line;
    scl = 1'b0;
  endtask
  // also a repeated start when entered with the clock low
  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask
  // msb first, line released in the ack slot, so a read byte ends in a nack
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // address, command byte, data byte
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] cmd, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, r, a0);
    byte_io(cmd, r, a1);
    byte_io(d, r, a2);
    stop();
    ok = a0 && a1 && a2;
  endtask
  // address, command byte, repeated start, read address, one byte
  task automatic reg_read(input logic [6:0] dev, input logic [7:0] cmd, output logic [7:0] d,
                          output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, r, a0);
    byte_io(cmd, r, a1);
    start();
    byte_io({dev, 1'b1}, r, a2);
    byte_io(8'hff, d, a3);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule

// ===== test_dual_sim_mux_control_regs.sv
// Purpose: self-checking bench of the dual slot card mux control block
// Assumes: board pulls the strap pin, pull-ups on all open-drain lines
// Notes: register reads are scored by a queue watcher, pins directly
`timescale 1ns/100ps
module test_dual_sim_mux_control_regs;
  import dsmcr_pkg::*;
  `define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) mis(nm, e, s); end
  localparam logic [7:0] ID = 8'h96;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic host_reset_n_in = 1'b1;
  logic strap = 1'b0;
  logic host_card_reset = 1'b0;
  logic host_card_clock = 1'b0;
  logic host_data_low = 1'b0;
  logic card_pull = 1'b0;
  logic scl, sda_low, sda_oe, irq_oe, host_card_data_oe, ok;
  logic a_rst, a_clk, a_oe, a_en, a_sel, a_pd, b_rst, b_clk, b_oe, b_en, b_sel, b_pd;
  logic [6:0] dev = ADDR_STRAP_LOW;
  logic [7:0] seen, e_tmp, c, r, st;
  logic [7:0] exp_q[$];
  string nm_q[$];
  string n_tmp;
  event got;
  int n_mismatch = 0;
  int samples_checked = 0;
  int rise_a = 0;
  int rise_b = 0;
  wire sda_line = !(sda_low || sda_oe);

  always #2 sys_clk = !sys_clk;

  // card side: pull-ups, plus a card pulling both slot lines low on card_pull
  dsmcr_top #(.MAKER_ID(4'h9), .DEVICE_ID(4'h6)) uut ( // arbitrary id values
    .sys_clk(sys_clk), .rst(rst), .host_reset_n_in(host_reset_n_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .irq_in(irq_oe ? 1'b0 : strap), .irq_out(), .irq_oe(irq_oe),
    .host_card_reset(host_card_reset), .host_card_clock(host_card_clock),
    .host_card_data_in(!(host_data_low || host_card_data_oe)), .host_card_data_out(),
    .host_card_data_oe(host_card_data_oe), .slot_a_card_reset(a_rst),
    .slot_a_card_clock(a_clk), .slot_a_card_data_in(!(a_oe || card_pull)),
    .slot_a_card_data_out(),
    .slot_a_card_data_oe(a_oe), .slot_a_supply_en(a_en), .slot_a_supply_sel(a_sel),
    .slot_a_pulldown(a_pd), .slot_b_card_reset(b_rst), .slot_b_card_clock(b_clk),
    .slot_b_card_data_in(!(b_oe || card_pull)), .slot_b_card_data_out(),
    .slot_b_card_data_oe(b_oe),
    .slot_b_supply_en(b_en), .slot_b_supply_sel(b_sel), .slot_b_pulldown(b_pd)
  );
  dsmcr_host_model hm (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  task automatic mis(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_mismatch++;
    $display("[ERR] %s expected %h seen %h", nm, e, s);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // state 00 with the regulator on reads back as powered
  function automatic logic [1:0] code(input logic [3:0] n);
    return (n[3:2] == ST_OFF && n[0]) ? ST_POWERED : n[3:2];
  endfunction
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e, input string nm);
    logic [7:0] v;
    logic a;
    hm.reg_read(dev, cmd, v, a);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    seen = v;
    ->got;
    `CHK("read ack", 1'b1, a)
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic a;
    hm.reg_write(dev, cmd, d, a);
    `CHK("write ack", 1'b1, a)
  endtask
  // strap set well before release so the sample is clean
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    wait_n(10);
    rst = 1'b0;
    wait_n(5);
  endtask
  // watcher scores each read against the oldest note
  always @(got) begin
    e_tmp = exp_q.pop_front();
    n_tmp = nm_q.pop_front();
    `CHK(n_tmp, e_tmp, seen)
  end
  always @(posedge a_clk) rise_a++;
  always @(posedge b_clk) rise_b++;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // about twice the expected run
  initial begin
    #250000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    do_reset(1'b0);
    rd(OFF_HW_ID, ID, "hw id");
    rd(OFF_SW_VER, 8'h00, "driver version");
    rd(OFF_STATUS, RST_STATUS, "status");
    rd(OFF_CTRL, RST_CTRL, "control");
    `CHK("pulldowns", 2'b11, {a_pd, b_pd})
    // read-only and foreign-address writes change nothing, an unmapped command reads zero
    wr(OFF_HW_ID, 8'h0f);
    wr(OFF_SW_VER, 8'hff);
    rd(OFF_HW_ID, ID, "hw id kept");
    rd(OFF_SW_VER, 8'h00, "version kept");
    rd(8'h02, 8'h00, "unmapped");
    hm.reg_write(ADDR_STRAP_HIGH, OFF_CTRL, 8'h33, ok);
    `CHK("foreign address ack", 1'b0, ok)
    rd(OFF_CTRL, 8'h00, "control untouched");
    // state 10 in both slots first, then random settings
    r = 8'h41;
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'ha9 : r;
      r = lfsr(r);
      st = {code(c[7:4]), code(c[3:0]), 4'h0};
      wr(OFF_CTRL, c);
      rd(OFF_CTRL, c, "control");
      rd(OFF_STATUS, st, "status");
      `CHK("supplies", {c[5:4], c[1:0]}, {b_sel, b_en, a_sel, a_en})
      `CHK("pulldowns", {!st[6], !st[4]}, {b_pd, a_pd})
    end
    wr(OFF_CTRL, 8'h00);
    rd(OFF_STATUS, 8'h00, "status idle");
    // select slot a, then slot b; run link clock and data both ways through each
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, k ? 8'hd0 : 8'h0d);
      wait_n(4);
      `CHK("event raised", 1'b1, irq_oe)
      rise_a = 0;
      rise_b = 0;
      host_card_reset = 1'b1;
      repeat (8) begin
        wait_n(4);
        host_card_clock = 1'b1;
        wait_n(4);
        host_card_clock = 1'b0;
      end
      wait_n(8);
      `CHK("slot a clocks", k ? 0 : 8, rise_a)
      `CHK("slot b clocks", k ? 8 : 0, rise_b)
      `CHK("card resets", k ? 2'b01 : 2'b10, {a_rst, b_rst})
      host_data_low = 1'b1;
      wait_n(8);
      `CHK("data to card", k ? 2'b01 : 2'b10, {a_oe, b_oe})
      host_data_low = 1'b0;
      wait_n(8);
      `CHK("data released", 2'b00, {a_oe, b_oe})
      card_pull = 1'b1;
      wait_n(8);
      `CHK("data to host", 3'b100, {host_card_data_oe, a_oe, b_oe})
      card_pull = 1'b0;
      wait_n(8);
      `CHK("host released", 1'b0, host_card_data_oe)
      rd(OFF_STATUS, k ? 8'hc0 : 8'h30, "status active");
      wait_n(4);
      `CHK("event cleared", 1'b0, irq_oe)
    end
    // reset through the host pin while slot b is live
    host_reset_n_in = 1'b0;
    wait_n(8);
    `CHK("held in reset", 6'b000011, {a_en, a_rst, b_en, b_rst, a_pd, b_pd})
    host_reset_n_in = 1'b1;
    wait_n(6);
    rd(OFF_CTRL, RST_CTRL, "control after pin reset");
    // high strap moves the device to the other address pair
    do_reset(1'b1);
    dev = ADDR_STRAP_HIGH;
    rd(OFF_HW_ID, ID, "id at high strap");
    hm.reg_write(ADDR_STRAP_LOW, OFF_CTRL, 8'h01, ok);
    `CHK("low address ack", 1'b0, ok)
    wrap_up();
  end
endmodule
